// file: src/pmse_pkg.sv
// Shared constants and types for the PoE management serial and event logic
package pmse_pkg;
  localparam int NPORT = 4;
  localparam int CLK_MHZ = 100;
  localparam int TICK_US = 100;
  localparam int TICK_CYCLES_DEF = TICK_US * CLK_MHZ;
  localparam int TICKS_PER_MS = 1000 / TICK_US;
  localparam int STARTUP_MS = 60;
  localparam int STARTUP_SLACK_MS = 5;
  localparam int CUTOFF_MS = 60;
  localparam int RETRY_MS = 750;
  localparam int CUT_UP_STEP = 15;
  localparam int CNT_W = 14;
  localparam logic [CNT_W-1:0] STARTUP_TICKS = CNT_W'(STARTUP_MS * TICKS_PER_MS);
  localparam logic [CNT_W-1:0] STARTUP_TRIP = CNT_W'((STARTUP_MS - STARTUP_SLACK_MS) * TICKS_PER_MS);
  localparam logic [CNT_W-1:0] CUT_UP = CNT_W'(CUT_UP_STEP);
  localparam logic [CNT_W-1:0] CUT_DOWN = CNT_W'(1);
  localparam logic [CNT_W-1:0] CUT_LIMIT = CNT_W'(CUTOFF_MS * TICKS_PER_MS * CUT_UP_STEP);
  localparam logic [CNT_W-1:0] RETRY_TICKS = CNT_W'(RETRY_MS * TICKS_PER_MS);
  localparam logic [2:0] ADDR_HI = 3'h2;
  localparam logic [6:0] GLOBAL_ADDR = 7'h30;
  localparam logic [6:0] ARA_ADDR = 7'h0c;
  localparam logic [7:0] REG_INT_SUM = 8'h00;
  localparam logic [7:0] REG_EVT_MASK = 8'h01;
  localparam logic [7:0] REG_EVT_BASE = 8'h02;
  localparam logic [7:0] REG_STAT_BASE = 8'h06;
  localparam logic [7:0] REG_DEV_STAT = 8'h1d;
  localparam int EVT_PEN = 0;
  localparam int EVT_PGOOD = 1;
  localparam int EVT_DET = 2;
  localparam int EVT_CLS = 3;
  localparam int EVT_DISC = 4;
  localparam int EVT_TSTART = 5;
  localparam int EVT_TCUT = 6;
  localparam logic [7:0] EVT_IRQ_SEL = 8'h6f;
  localparam logic [7:0] MASK_RESET = 8'h6b;
  localparam int SUM_DEV = 4;
  localparam int SUM_UV = 5;
  localparam int SUM_TEMP = 6;
  localparam int DEV_UV = 5;
  localparam int DEV_TEMP = 6;
  localparam int ST_PGOOD = 0;
  localparam int ST_PEN = 1;
  localparam int ST_CLS_LSB = 2;
  localparam int ST_DET_LSB = 5;
  localparam logic [2:0] RESULT_UNKNOWN = 3'h0;
  typedef enum logic [1:0] {PMSE_OFF, PMSE_STARTUP, PMSE_ON, PMSE_BACKOFF} pmse_port_e;
  typedef enum logic [2:0] {PMSE_IDLE, PMSE_RX, PMSE_ACK, PMSE_TX, PMSE_TXACK} pmse_i2c_e;
endpackage : pmse_pkg

// file: src/pmse_byte_if.sv
// Byte-level link between the serial slave and the register core
`timescale 1ns/10ps
`default_nettype none
interface pmse_byte_if;
  logic rx_valid;
  logic rx_first;
  logic [7:0] rx_data;
  logic ack;
  logic tx_load;
  logic [7:0] tx_data;
  logic tx_arb;
  logic tx_done;
  logic tx_lost;
  logic stop;
  modport slave (output rx_valid, rx_first, rx_data, tx_load, tx_done, tx_lost, stop,
                 input ack, tx_data, tx_arb);
  modport core (input rx_valid, rx_first, rx_data, tx_load, tx_done, tx_lost, stop,
                output ack, tx_data, tx_arb);
endinterface : pmse_byte_if
`default_nettype wire

// file: src/pmse_i2c_slave.sv
// Two-wire bus slave: bit timing, acknowledge and arbitrated transmit
`timescale 1ns/10ps
`default_nettype none
module pmse_i2c_slave (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_oe_o,
  pmse_byte_if.slave bus
);
  import pmse_pkg::*;
  logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
  logic scl_rise, scl_fall, start_c, stop_c;
  pmse_i2c_e st_reg, st_next;
  logic [7:0] sh_reg, sh_next;
  logic [3:0] cnt_reg, cnt_next;
  logic first_reg, first_next, rd_reg, rd_next, mack_reg, mack_next, oe_next;

  always_ff @(posedge clk_i) begin
    scl_s1 <= scl_i;
    sda_s1 <= sda_i;
    scl_s2 <= scl_s1;
    sda_s2 <= sda_s1;
    scl_d <= scl_s2;
    sda_d <= sda_s2;
  end

  assign scl_rise = scl_s2 & ~scl_d;
  assign scl_fall = ~scl_s2 & scl_d;
  assign start_c = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign stop_c = scl_s2 & scl_d & ~sda_d & sda_s2;

  always_comb begin
    st_next = st_reg;
    sh_next = sh_reg;
    cnt_next = cnt_reg;
    first_next = first_reg;
    rd_next = rd_reg;
    mack_next = mack_reg;
    oe_next = sda_oe_o;
    bus.rx_valid = 1'b0;
    bus.rx_first = first_reg;
    bus.rx_data = sh_reg;
    bus.tx_load = 1'b0;
    bus.tx_done = 1'b0;
    bus.tx_lost = 1'b0;
    bus.stop = stop_c;
    if (start_c) begin
      st_next = PMSE_RX;
      cnt_next = 4'h0;
      first_next = 1'b1;
      oe_next = 1'b0;
    end else if (stop_c) begin
      st_next = PMSE_IDLE;
      oe_next = 1'b0;
    end else begin
      unique case (st_reg)
        PMSE_IDLE: ;
        PMSE_RX: begin
          if (scl_rise) begin
            sh_next = {sh_reg[6:0], sda_s2};
            cnt_next = cnt_reg + 4'h1;
          end else if (scl_fall && cnt_reg == 4'h8) begin
            bus.rx_valid = 1'b1;
            rd_next = first_reg & sh_reg[0];
            // Ack is low data held through the ninth clock
            oe_next = bus.ack;
            st_next = bus.ack ? PMSE_ACK : PMSE_IDLE;
          end
        end
        PMSE_ACK: begin
          if (scl_fall) begin
            first_next = 1'b0;
            cnt_next = 4'h0;
            if (rd_reg) begin
              bus.tx_load = 1'b1;
              sh_next = bus.tx_data;
              oe_next = ~bus.tx_data[7];
              st_next = PMSE_TX;
            end else begin
              oe_next = 1'b0;
              st_next = PMSE_RX;
            end
          end
        end
        PMSE_TX: begin
          if (scl_rise) begin
            if (bus.tx_arb && sda_s2 != sh_reg[7]) begin
              // Lost: float the line at once
              oe_next = 1'b0;
              bus.tx_done = 1'b1;
              bus.tx_lost = 1'b1;
              st_next = PMSE_IDLE;
            end else begin
              cnt_next = cnt_reg + 4'h1;
            end
          end else if (scl_fall) begin
            if (cnt_reg == 4'h8) begin
              oe_next = 1'b0;
              bus.tx_done = 1'b1;
              st_next = PMSE_TXACK;
            end else begin
              sh_next = {sh_reg[6:0], 1'b0};
              oe_next = ~sh_reg[6];
            end
          end
        end
        PMSE_TXACK: begin
          if (scl_rise) begin
            mack_next = ~sda_s2;
          end else if (scl_fall) begin
            cnt_next = 4'h0;
            if (mack_reg) begin
              bus.tx_load = 1'b1;
              sh_next = bus.tx_data;
              oe_next = ~bus.tx_data[7];
              st_next = PMSE_TX;
            end else begin
              st_next = PMSE_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= PMSE_IDLE;
      sh_reg <= 8'h00;
      cnt_reg <= 4'h0;
      first_reg <= 1'b0;
      rd_reg <= 1'b0;
      mack_reg <= 1'b0;
      sda_oe_o <= 1'b0;
    end else begin
      st_reg <= st_next;
      sh_reg <= sh_next;
      cnt_reg <= cnt_next;
      first_reg <= first_next;
      rd_reg <= rd_next;
      mack_reg <= mack_next;
      sda_oe_o <= oe_next;
    end
  end
endmodule : pmse_i2c_slave
`default_nettype wire

// file: src/pmse_port.sv
// One port: power sequencing, overload timing and event pulses
`timescale 1ns/10ps
`default_nettype none
module pmse_port #(
  parameter bit AUTO_START = 1'b1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic over_cur_i,
  input wire logic near_rail_i,
  input wire logic clamp_i,
  input wire logic disc_i,
  input wire logic supply_lost_i,
  input wire logic det_done_i,
  input wire logic [2:0] det_res_i,
  input wire logic cls_done_i,
  input wire logic [2:0] cls_res_i,
  input wire logic sig_good_i,
  output logic fet_on_o,
  output logic [7:0] ev_o,
  output logic [7:0] status_o
);
  import pmse_pkg::*;
  pmse_port_e st_reg, st_next;
  logic [CNT_W-1:0] tmr_reg, tmr_next, ovl_reg, ovl_next;
  logic [2:0] cls_reg, cls_next, det_reg, det_next;
  logic det_prev, cls_prev, det_edge, cls_edge, overload, off_c;
  logic [7:0] ev_next;

  assign det_edge = det_done_i & ~det_prev;
  assign cls_edge = cls_done_i & ~cls_prev;
  assign overload = over_cur_i | ~near_rail_i;

  always_comb begin
    st_next = st_reg;
    tmr_next = tmr_reg;
    ovl_next = ovl_reg;
    cls_next = cls_reg;
    det_next = det_reg;
    ev_next = 8'h00;
    off_c = 1'b0;
    if (det_edge) begin
      det_next = det_res_i;
      ev_next[EVT_DET] = 1'b1;
    end
    if (cls_edge) begin
      cls_next = cls_res_i;
      ev_next[EVT_CLS] = sig_good_i;
    end
    unique case (st_reg)
      PMSE_OFF: begin
        // Retry also needs a fresh good signature
        if (AUTO_START && cls_edge && sig_good_i) begin
          st_next = PMSE_STARTUP;
          tmr_next = '0;
          ovl_next = '0;
          ev_next[EVT_PEN] = 1'b1;
        end
      end
      PMSE_STARTUP: begin
        if (supply_lost_i) begin
          off_c = 1'b1;
        end else if (clamp_i) begin
          off_c = 1'b1;
          ev_next[EVT_TCUT] = 1'b1;
        end else if (tick_i) begin
          tmr_next = tmr_reg + CNT_W'(1);
          ovl_next = ovl_reg + CNT_W'(overload);
          if (tmr_next == STARTUP_TICKS) begin
            if (ovl_next >= STARTUP_TRIP) begin
              off_c = 1'b1;
              ev_next[EVT_TSTART] = 1'b1;
            end else begin
              st_next = PMSE_ON;
              ovl_next = '0;
              ev_next[EVT_PGOOD] = 1'b1;
            end
          end
        end
      end
      PMSE_ON: begin
        if (supply_lost_i) begin
          off_c = 1'b1;
        end else if (disc_i) begin
          off_c = 1'b1;
          ev_next[EVT_DISC] = 1'b1;
        end else if (clamp_i) begin
          off_c = 1'b1;
          ev_next[EVT_TCUT] = 1'b1;
        end else if (tick_i) begin
          // Up 15, down 1: duty under 1/16 drains to zero
          if (overload) begin
            ovl_next = ovl_reg + CUT_UP;
          end else if (ovl_reg != '0) begin
            ovl_next = ovl_reg - CUT_DOWN;
          end
          if (ovl_next > CUT_LIMIT) begin
            off_c = 1'b1;
            ev_next[EVT_TCUT] = 1'b1;
          end
        end
      end
      PMSE_BACKOFF: begin
        if (tick_i) begin
          tmr_next = tmr_reg + CNT_W'(1);
          if (tmr_reg > RETRY_TICKS) begin
            st_next = PMSE_OFF;
          end
        end
      end
    endcase
    if (off_c) begin
      st_next = supply_lost_i ? PMSE_OFF : PMSE_BACKOFF;
      tmr_next = '0;
      ovl_next = '0;
      cls_next = RESULT_UNKNOWN;
      det_next = RESULT_UNKNOWN;
    end
  end

  always_comb begin
    status_o = 8'h00;
    status_o[ST_PGOOD] = (st_reg == PMSE_ON) & near_rail_i;
    status_o[ST_PEN] = fet_on_o;
    status_o[ST_CLS_LSB +: 3] = cls_reg;
    status_o[ST_DET_LSB +: 3] = det_reg;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= PMSE_OFF;
      tmr_reg <= '0;
      ovl_reg <= '0;
      cls_reg <= RESULT_UNKNOWN;
      det_reg <= RESULT_UNKNOWN;
      det_prev <= 1'b0;
      cls_prev <= 1'b0;
      ev_o <= 8'h00;
      fet_on_o <= 1'b0;
    end else begin
      st_reg <= st_next;
      tmr_reg <= tmr_next;
      ovl_reg <= ovl_next;
      cls_reg <= cls_next;
      det_reg <= det_next;
      det_prev <= det_done_i;
      cls_prev <= cls_done_i;
      ev_o <= ev_next;
      fet_on_o <= (st_next == PMSE_STARTUP) | (st_next == PMSE_ON);
    end
  end
endmodule : pmse_port
`default_nettype wire

// file: src/pmse_top.sv
// Management top: bus registers, interrupt, strap capture, four ports
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - Address byte bit zero selects read
// - Device acknowledges its own address and every later received byte
// - Master acknowledge sampled; STOP ends transfer
// - Address is 010 plus four straps
// - Broadcast address 0x30 also accepted
// - Straps with bit3 clear, bit1 set invalid
// - Straps captured once after power up
// - Ports start auto or shutdown by option
// - Alert read answers own address plus one
// - Match releases interrupt; mismatch floats data
// - No new interrupt until source cleared
// - Interrupt low while any summary bit set, until released by alert match
// - Port interrupt is masked event OR, disconnect event excluded
// - Supply or temperature change sets device bit
// - Event registers clear when read
// - Startup overload: overloaded 55 of 60ms
// - Cutoff: 15:1 integrator beyond 60ms trips
// - Overload is current or rail error
// - Auto retry after 750ms, good signature
// - Flags for class, detect, on, powered good
// - Disconnect flag only from disconnect sensing
// - Status: good, enabled, class, detect
// - Device status read clears change bits
module pmse_top #(
  parameter int unsigned TICK_CYCLES = pmse_pkg::TICK_CYCLES_DEF,
  parameter bit AUTO_START = 1'b1
) (
  input wire logic CORE_CLK_I,
  input wire logic SRST_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_O,
  output logic INT_O,
  output logic INT_OE_O,
  input wire logic ADDR_STRAP_BIT0_I,
  input wire logic ADDR_STRAP_BIT1_I,
  input wire logic ADDR_STRAP_BIT2_I,
  input wire logic ADDR_STRAP_BIT3_I,
  input wire logic [pmse_pkg::NPORT-1:0] CUTOFF_LEVEL_EXCEEDED_I,
  input wire logic [pmse_pkg::NPORT-1:0] NEAR_RAIL_I,
  input wire logic [pmse_pkg::NPORT-1:0] CLAMP_TRIP_I,
  input wire logic [pmse_pkg::NPORT-1:0] DISCONNECT_SENSED_I,
  input wire logic [pmse_pkg::NPORT-1:0] DETECTION_CYCLE_DONE_I,
  input wire logic [3*pmse_pkg::NPORT-1:0] DETECT_RESULT_I,
  input wire logic [pmse_pkg::NPORT-1:0] VALID_SIGNATURE_CLASSIFIED_I,
  input wire logic [3*pmse_pkg::NPORT-1:0] CLASS_RESULT_I,
  input wire logic [pmse_pkg::NPORT-1:0] SIGNATURE_GOOD_I,
  input wire logic SUPPLY_LOST_I,
  input wire logic OVER_TEMP_I,
  input wire logic SUPPLY_UVLO_I,
  output logic [pmse_pkg::NPORT-1:0] PORT_ON_O
);
  import pmse_pkg::*;

  localparam int IN_W = 4 + 7 * NPORT + 6 * NPORT + 3;

  pmse_byte_if bus ();

  logic [IN_W-1:0] raw_in, in_s1, in_s2;
  logic [3:0] strap_s;
  logic [NPORT-1:0] ocur_s, rail_s, clamp_s, disc_s, det_s, cls_s, sig_s;
  logic [3*NPORT-1:0] detres_s, clsres_s;
  logic lost_s, temp_s, uv_s;

  logic [31:0] tick_cnt_reg, tick_cnt_next;
  logic tick_reg, tick_next;
  logic [3:0] strap_reg, strap_next;
  logic strap_taken_reg, strap_taken_next;

  logic sel_reg, sel_next, ara_reg, ara_next, pset_reg, pset_next;
  logic [7:0] ptr_reg, ptr_next, mask_reg, mask_next, rd_data;
  logic [1:0] evt_idx, stat_idx;
  logic [NPORT-1:0] port_clr, port_irq;
  logic dev_clr, ara_hit;
  logic [7:0] flags_reg [NPORT];
  logic [7:0] flags_next [NPORT];
  logic [7:0] ev [NPORT];
  logic [7:0] status [NPORT];

  logic temp_chg_reg, temp_chg_next, uv_chg_reg, uv_chg_next;
  logic temp_prev_reg, uv_prev_reg;
  logic rel_reg, rel_next, int_next;
  logic [7:0] summary;

  function automatic logic strap_ok(input logic [3:0] s);
    strap_ok = ~(s[1] & ~s[3]);
  endfunction : strap_ok

  function automatic logic addr_hit(input logic [6:0] a, input logic [3:0] s);
    addr_hit = (a == {ADDR_HI, s} && strap_ok(s)) || a == GLOBAL_ADDR;
  endfunction : addr_hit

  // Everything from the analog side crosses two flops first
  assign raw_in = {ADDR_STRAP_BIT3_I, ADDR_STRAP_BIT2_I, ADDR_STRAP_BIT1_I, ADDR_STRAP_BIT0_I,
                   CUTOFF_LEVEL_EXCEEDED_I, NEAR_RAIL_I, CLAMP_TRIP_I, DISCONNECT_SENSED_I,
                   DETECTION_CYCLE_DONE_I, VALID_SIGNATURE_CLASSIFIED_I, SIGNATURE_GOOD_I,
                   DETECT_RESULT_I, CLASS_RESULT_I, SUPPLY_LOST_I, OVER_TEMP_I, SUPPLY_UVLO_I};
  assign {strap_s, ocur_s, rail_s, clamp_s, disc_s, det_s, cls_s, sig_s,
          detres_s, clsres_s, lost_s, temp_s, uv_s} = in_s2;

  always_ff @(posedge CORE_CLK_I) begin
    in_s1 <= raw_in;
    in_s2 <= in_s1;
  end

  always_comb begin
    tick_next = 1'b0;
    tick_cnt_next = tick_cnt_reg + 32'h1;
    if (tick_cnt_reg >= TICK_CYCLES - 32'h1) begin
      tick_cnt_next = 32'h0;
      tick_next = 1'b1;
    end
    strap_next = strap_reg;
    strap_taken_next = 1'b1;
    // Caught once after reset release, never re-read
    if (!strap_taken_reg) begin
      strap_next = strap_s;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      tick_cnt_reg <= 32'h0;
      tick_reg <= 1'b0;
      strap_reg <= 4'h0;
      strap_taken_reg <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      tick_reg <= tick_next;
      strap_reg <= strap_next;
      strap_taken_reg <= strap_taken_next;
    end
  end

  pmse_i2c_slave u_slave (
    .clk_i(CORE_CLK_I),
    .rst_i(SRST_I),
    .scl_i(SCL_I),
    .sda_i(SDA_I),
    .sda_oe_o(SDA_OE_O),
    .bus(bus.slave)
  );

  for (genvar g = 0; g < NPORT; g++) begin : g_port
    pmse_port #(.AUTO_START(AUTO_START)) u_port (
      .clk_i(CORE_CLK_I),
      .rst_i(SRST_I),
      .tick_i(tick_reg),
      .over_cur_i(ocur_s[g]),
      .near_rail_i(rail_s[g]),
      .clamp_i(clamp_s[g]),
      .disc_i(disc_s[g]),
      .supply_lost_i(lost_s),
      .det_done_i(det_s[g]),
      .det_res_i(detres_s[3*g +: 3]),
      .cls_done_i(cls_s[g]),
      .cls_res_i(clsres_s[3*g +: 3]),
      .sig_good_i(sig_s[g]),
      .fet_on_o(PORT_ON_O[g]),
      .ev_o(ev[g]),
      .status_o(status[g])
    );
  end

  assign evt_idx = 2'(ptr_reg - REG_EVT_BASE);
  assign stat_idx = 2'(ptr_reg - REG_STAT_BASE);
  assign ara_hit = bus.rx_data[7:1] == ARA_ADDR && bus.rx_data[0] && INT_OE_O;

  always_comb begin
    rd_data = 8'h00;
    if (ptr_reg == REG_INT_SUM) begin
      rd_data = summary;
    end else if (ptr_reg == REG_EVT_MASK) begin
      rd_data = mask_reg;
    end else if (ptr_reg >= REG_EVT_BASE && ptr_reg < REG_STAT_BASE) begin
      rd_data = flags_reg[evt_idx];
    end else if (ptr_reg >= REG_STAT_BASE && ptr_reg < REG_STAT_BASE + 8'(NPORT)) begin
      rd_data = status[stat_idx];
    end else if (ptr_reg == REG_DEV_STAT) begin
      rd_data[DEV_TEMP] = temp_s;
      rd_data[DEV_UV] = uv_s;
    end
  end

  always_comb begin
    sel_next = sel_reg;
    ara_next = ara_reg;
    pset_next = pset_reg;
    ptr_next = ptr_reg;
    mask_next = mask_reg;
    port_clr = '0;
    dev_clr = 1'b0;
    bus.tx_data = 8'h00;
    bus.tx_arb = ara_reg;
    bus.ack = bus.rx_first ? (addr_hit(bus.rx_data[7:1], strap_reg) | ara_hit) : sel_reg;
    if (bus.rx_valid && bus.rx_first) begin
      sel_next = bus.ack;
      ara_next = ara_hit;
      pset_next = 1'b0;
    end else if (bus.rx_valid && sel_reg) begin
      // First data byte of a write sets the pointer
      if (!pset_reg) begin
        ptr_next = bus.rx_data;
        pset_next = 1'b1;
      end else begin
        if (ptr_reg == REG_EVT_MASK) begin
          mask_next = bus.rx_data;
        end
        ptr_next = ptr_reg + 8'h1;
      end
    end
    if (bus.tx_load) begin
      if (ara_reg) begin
        bus.tx_data = {ADDR_HI, strap_reg, 1'b1};
      end else begin
        bus.tx_data = rd_data;
        ptr_next = ptr_reg + 8'h1;
        if (ptr_reg >= REG_EVT_BASE && ptr_reg < REG_STAT_BASE) begin
          port_clr[evt_idx] = 1'b1;
        end
        dev_clr = ptr_reg == REG_DEV_STAT;
      end
    end
    if (bus.stop) begin
      sel_next = 1'b0;
      ara_next = 1'b0;
    end
  end

  always_comb begin
    for (int i = 0; i < NPORT; i++) begin
      // A new event in the clearing cycle survives
      flags_next[i] = (flags_reg[i] & ~{8{port_clr[i]}}) | ev[i];
      port_irq[i] = |(flags_reg[i] & mask_reg & EVT_IRQ_SEL);
    end
    temp_chg_next = (temp_chg_reg & ~dev_clr) | (temp_s ^ temp_prev_reg);
    uv_chg_next = (uv_chg_reg & ~dev_clr) | (uv_s ^ uv_prev_reg);
    summary = 8'h00;
    summary[NPORT-1:0] = port_irq;
    summary[SUM_TEMP] = temp_chg_reg;
    summary[SUM_UV] = uv_chg_reg;
    summary[SUM_DEV] = temp_chg_reg | uv_chg_reg;
    rel_next = rel_reg;
    if (bus.tx_done && ara_reg && !bus.tx_lost) begin
      rel_next = 1'b1;
    end
    // Held off until every pending source has been read away
    if (summary == 8'h00) begin
      rel_next = 1'b0;
    end
    int_next = (summary != 8'h00) & ~rel_next;
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      sel_reg <= 1'b0;
      ara_reg <= 1'b0;
      pset_reg <= 1'b0;
      ptr_reg <= 8'h00;
      mask_reg <= MASK_RESET;
      for (int i = 0; i < NPORT; i++) begin
        flags_reg[i] <= 8'h00;
      end
      temp_chg_reg <= 1'b0;
      uv_chg_reg <= 1'b0;
      temp_prev_reg <= 1'b0;
      uv_prev_reg <= 1'b0;
      rel_reg <= 1'b0;
      INT_OE_O <= 1'b0;
      INT_O <= 1'b0;
      SDA_O <= 1'b0;
    end else begin
      sel_reg <= sel_next;
      ara_reg <= ara_next;
      pset_reg <= pset_next;
      ptr_reg <= ptr_next;
      mask_reg <= mask_next;
      for (int i = 0; i < NPORT; i++) begin
        flags_reg[i] <= flags_next[i];
      end
      temp_chg_reg <= temp_chg_next;
      uv_chg_reg <= uv_chg_next;
      temp_prev_reg <= temp_s;
      uv_prev_reg <= uv_s;
      rel_reg <= rel_next;
      INT_OE_O <= int_next;
      INT_O <= 1'b0;
      SDA_O <= 1'b0;
    end
  end
endmodule : pmse_top
`default_nettype wire

// file: testbench/pmse_top_properties.sv
// Port-level properties of the management top
`timescale 1ns/10ps
`default_nettype none
module pmse_top_properties (
  input wire logic CORE_CLK_I,
  input wire logic SRST_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  input wire logic SDA_O,
  input wire logic SDA_OE_O,
  input wire logic INT_O,
  input wire logic INT_OE_O,
  input wire logic [3:0] CLAMP_TRIP_I,
  input wire logic [3:0] SIGNATURE_GOOD_I,
  input wire logic SUPPLY_LOST_I,
  input wire logic [3:0] PORT_ON_O
);
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (SRST_I);
  a_sda_pull_only: assert property (SDA_O == 1'b0) else $error("data pin driven high");
  a_int_pull_only: assert property (INT_O == 1'b0) else $error("int pin driven high");
  a_reset_quiet: assert property ($fell(SRST_I) |-> !SDA_OE_O && !INT_OE_O && PORT_ON_O == 4'h0)
    else $error("outputs active after reset");
  // Data may only move a few cycles after the clock fall
  a_data_holds: assert property ($fell(SCL_I) |=> $stable(SDA_OE_O) [*2]) else $error("data moved at fall");
  a_stop_frees: assert property (SCL_I && $rose(SDA_I) |=> !SDA_OE_O [*4]) else $error("driven after stop");
  a_supply_off: assert property (SUPPLY_LOST_I |-> ##[1:4] PORT_ON_O == 4'h0) else $error("on without rail");
  a_clamp_off: assert property (CLAMP_TRIP_I[0] |-> ##[1:4] !PORT_ON_O[0]) else $error("on after clamp");
  a_on_needs_sig: assert property ($rose(PORT_ON_O[0]) |-> SIGNATURE_GOOD_I[0]) else $error("on without sig");
endmodule : pmse_top_properties
`default_nettype wire

// file: testbench/pmse_host_model.sv
// Bus master model: open-drain data, clock idles high outside frames
`timescale 1ns/10ps
`default_nettype none
module pmse_host_model (
  input wire logic clk_i,
  output logic scl_o,
  output logic sda_low_o,
  input wire logic sda_i
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic start();
    // Off-edge phase: pins never move on a sampling edge
    @(posedge clk_i);
    #1 sda_low_o = 1'b0;
    #31.25 scl_o = 1'b1;
    #31.25 sda_low_o = 1'b1;
    #31.25 scl_o = 1'b0;
    #31.25;
  endtask : start
  // Data moves mid-low phase so the slave never mistakes it for start or stop
  task automatic bit_io(input logic b, output logic r);
    sda_low_o = ~b;
    #31.25 scl_o = 1'b1;
    #31.25 r = sda_i;
    #31.25 scl_o = 1'b0;
    #31.25;
  endtask : bit_io
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(a, k);
  endtask : xfer
  task automatic stop();
    sda_low_o = 1'b1;
    #31.25 scl_o = 1'b1;
    #31.25 sda_low_o = 1'b0;
    #31.25;
  endtask : stop
endmodule : pmse_host_model
`default_nettype wire

// file: testbench/testbench.sv
// Bench for the management top with a bus master model
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import pmse_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic lost = 1'b0, temp = 1'b0;
  logic [3:0] strap = 4'h0, clamp = 4'h0, det = 4'h0, cls = 4'h0, sig = 4'h0;
  logic [11:0] det_res = 12'h0, cls_res = 12'h0;
  logic scl, host_low, sda_oe, int_oe;
  logic [3:0] pon;
  wire sda = ~(host_low | sda_oe); // Pull-up wins when nobody pulls
  int miscompares = 0;
  int tests_run = 0;
  pmse_host_model i_host (.clk_i(clk), .scl_o(scl), .sda_low_o(host_low), .sda_i(sda));
  pmse_top #(.TICK_CYCLES(10)) i_dut (.CORE_CLK_I(clk), .SRST_I(srst), .SCL_I(scl), .SDA_I(sda), .SDA_O(),
    .SDA_OE_O(sda_oe), .INT_O(), .INT_OE_O(int_oe), .ADDR_STRAP_BIT0_I(strap[0]), .ADDR_STRAP_BIT1_I(strap[1]),
    .ADDR_STRAP_BIT2_I(strap[2]), .ADDR_STRAP_BIT3_I(strap[3]), .CUTOFF_LEVEL_EXCEEDED_I(4'h0),
    .NEAR_RAIL_I(4'hf), .CLAMP_TRIP_I(clamp), .DISCONNECT_SENSED_I(4'h0), .DETECTION_CYCLE_DONE_I(det),
    .DETECT_RESULT_I(det_res), .VALID_SIGNATURE_CLASSIFIED_I(cls), .CLASS_RESULT_I(cls_res),
    .SIGNATURE_GOOD_I(sig), .SUPPLY_LOST_I(lost), .OVER_TEMP_I(temp), .SUPPLY_UVLO_I(1'b0), .PORT_ON_O(pon));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic do_reset(input logic [3:0] s);
    @(posedge clk);
    #1 strap = s;
    srst = 1'b1;
    repeat (6) @(posedge clk);
    #1 srst = 1'b0;
    repeat (4) @(posedge clk);
  endtask : do_reset
  task automatic probe(input logic [6:0] a, input logic nak);
    logic [7:0] q;
    logic k;
    i_host.start();
    i_host.xfer({a, 1'b0}, 1'b1, q, k);
    i_host.stop();
    check({7'h0, k}, {7'h0, nak});
  endtask : probe
  // Register access at strapped address 0x25; a read ends with NACK
  task automatic acc(input logic [7:0] p, input logic [7:0] v, input logic rd, output logic [7:0] q);
    logic k;
    i_host.start();
    i_host.xfer(8'h4a, 1'b1, q, k);
    check({7'h0, k}, 8'h00);
    i_host.xfer(p, 1'b1, q, k);
    if (rd) begin
      i_host.start();
      i_host.xfer(8'h4b, 1'b1, q, k);
    end
    i_host.xfer(rd ? 8'hff : v, 1'b1, q, k);
    if (!rd) check({7'h0, k}, 8'h00);
    i_host.stop();
  endtask : acc
  task automatic strap_bad();
    do_reset(4'h2);
    probe(7'h22, 1'b1);
    probe(7'h30, 1'b0);
  endtask : strap_bad
  task automatic strap_good();
    logic [7:0] q;
    do_reset(4'h5);
    strap = 4'ha;
    probe(7'h2a, 1'b1);
    probe(7'h05, 1'b1);
    probe(7'h25, 1'b0);
    acc(REG_EVT_MASK, 8'h00, 1'b1, q);
    check(q, MASK_RESET);
    acc(REG_EVT_MASK, 8'h7f, 1'b0, q);
    acc(REG_EVT_MASK, 8'h00, 1'b1, q);
    check(q, 8'h7f);
  endtask : strap_good
  task automatic alert_flow();
    logic [7:0] q;
    logic k;
    @(posedge clk);
    #1 {sig, det_res, cls_res, det} = {4'h1, 12'h004, 12'h003, 4'h1};
    @(posedge clk);
    #1 cls = 4'h1;
    // Startup interval is 600 ticks of 10 cycles
    repeat (6100) @(posedge clk);
    check({7'h0, pon[0]}, 8'h01);
    check({7'h0, int_oe}, 8'h01);
    i_host.start();
    i_host.xfer({ARA_ADDR, 1'b1}, 1'b1, q, k);
    i_host.xfer(8'hff, 1'b1, q, k);
    i_host.stop();
    check(q, {ADDR_HI, 4'h5, 1'b1});
    check({7'h0, int_oe}, 8'h00);
    acc(REG_EVT_BASE, 8'h00, 1'b1, q);
    check(q, 8'h0f);
    acc(REG_EVT_BASE, 8'h00, 1'b1, q);
    check(q, 8'h00);
    acc(REG_STAT_BASE, 8'h00, 1'b1, q);
    check(q, 8'h8f);
  endtask : alert_flow
  task automatic clamp_trip();
    logic [7:0] q;
    @(posedge clk);
    #1 clamp = 4'h1;
    repeat (5) @(posedge clk);
    check({7'h0, pon[0]}, 8'h00);
    acc(REG_EVT_BASE, 8'h00, 1'b1, q);
    check(q, 8'h40);
    @(posedge clk);
    #1 lost = 1'b1;
    repeat (5) @(posedge clk);
    #1 temp = 1'b1;
    acc(REG_INT_SUM, 8'h00, 1'b1, q);
    check(q, 8'h50);
    acc(REG_DEV_STAT, 8'h00, 1'b1, q);
    check(q, 8'h40);
    acc(REG_INT_SUM, 8'h00, 1'b1, q);
    check(q, 8'h00);
  endtask : clamp_trip
  task automatic close_out();
    $display("%0d checks, %0d mismatches", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out
  initial forever #5 clk = ~clk;
  initial begin
    strap_bad();
    strap_good();
    alert_flow();
    clamp_trip();
    close_out();
  end
  initial begin
    #300us;
    miscompares++;
    close_out();
  end
endmodule : testbench
bind pmse_top pmse_top_properties u_props (.CORE_CLK_I(CORE_CLK_I), .SRST_I(SRST_I), .SCL_I(SCL_I),
  .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O), .INT_O(INT_O), .INT_OE_O(INT_OE_O),
  .CLAMP_TRIP_I(CLAMP_TRIP_I), .SIGNATURE_GOOD_I(SIGNATURE_GOOD_I), .SUPPLY_LOST_I(SUPPLY_LOST_I),
  .PORT_ON_O(PORT_ON_O));
`default_nettype wire
